// *** slt_modem_model.sv ***
// Behavioural synchronous modem: bit clocks, receive data, capture of the sent line.
// Assumes the block shifts on falling clock edges; samples are taken on rising ones.
`timescale 1ns/10ps
module slt_modem_model (
   // Bench control
   input  wire logic   run_i,
   // Serial side
   input  wire logic   tx_line_i,
   output logic        tx_bit_clk_o,
   output logic        rx_bit_clk_o,
   output logic        rx_line_o,
   // Capture, newest bit on top
   output logic [31:0] word_o,
   output logic [15:0] count_o
);
   // ------------------------------------------------------------
   // Clocks stand high outside frames
   // ------------------------------------------------------------
   initial begin
      tx_bit_clk_o = 1'b1;
      rx_bit_clk_o = 1'b1;
      rx_line_o    = 1'b0;
      word_o       = 32'h0000_0000;
      count_o      = 16'h0000;
   end
   always begin
      wait (run_i);
      #62.5;
      tx_bit_clk_o = 1'b0;
      rx_bit_clk_o = 1'b0;
      // Toggles so a stale level never looks like data
      rx_line_o    = ~rx_line_o;
      #62.5;
      tx_bit_clk_o = 1'b1;
      rx_bit_clk_o = 1'b1;
      word_o       = {tx_line_i, word_o[31:1]};
      count_o      = count_o + 16'h0001;
   end
endmodule

// *** slt_pkg.sv ***
// Constants for the transmit control and status logic of a single-line synchronous interface.
// Assumes a 16-bit register strobed directly by the bus front end and a 100 MHz system clock.
//
// Summary of operation
// - Bit 14 is loop-test receiver data in loop modes; resets clear it.
// - Bit 13 is a single-step clock for both bit clocks in loops.
// - Bits 12:11 pick normal, internal loop, external loop or system test.
// - Bit 10 reads the receiver serial input level in loop modes.
// - Writing one to bit 8 makes a clear pulse and withholds slave sync.
// - Done flag bit 7 set by resets and first bit of a buffered character.
// - Done flag is read-only and cleared by the buffer load strobe.
// - Bit 6 with done set raises a transmitter interrupt request.
// - Bit 5 with fill-sent flag raises a transmitter interrupt request.
// - Send bit 4 enables transmission once a character is buffered.
// - Send cleared early: finish the current character, then go idle.
// - Half-duplex bit 3 disables the receiver while send is set.
// - Break bit 0 forces the serial output to space (low).
// - Bit 15 sets when a fill character goes out; read clears it.
// - Idle transmitter holds mark, clears its timing, leaves its flags as they are.
package slt_pkg;

   // ------------------------------------------------------------
   // Register field positions
   // ------------------------------------------------------------
   localparam int BIT_FILL_SENT  = 15;
   localparam int BIT_LOOP_DATA  = 14;
   localparam int BIT_SS_CLK     = 13;
   localparam int BIT_MODE_HI    = 12;
   localparam int BIT_MODE_LO    = 11;
   localparam int BIT_RX_MON     = 10;
   localparam int BIT_UNIT_RESET = 8;
   localparam int BIT_DONE       = 7;
   localparam int BIT_TX_IE      = 6;
   localparam int BIT_FILL_IE    = 5;
   localparam int BIT_SEND       = 4;
   localparam int BIT_HALF_DUPLEX_SELECT   = 3;
   localparam int BIT_BREAK      = 0;

   localparam int CSR_W  = 16;
   localparam int CHAR_W = 8;
   localparam int CNT_W  = 4;

   // ------------------------------------------------------------
   // Mode codes and line levels
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_NORMAL   = 2'h0;
   localparam logic [1:0] MODE_INT_LOOP = 2'h1;
   localparam logic [1:0] MODE_EXT_LOOP = 2'h2;
   localparam logic [1:0] MODE_SYS_TEST = 2'h3;

   localparam logic LINE_MARK  = 1'b1;
   localparam logic LINE_SPACE = 1'b0;

   localparam logic [CSR_W-1:0]  CSR_ZERO  = 16'h0000;
   localparam logic [CHAR_W-1:0] CHAR_ONES = 8'hff;
   localparam logic [CNT_W-1:0]  CNT_ZERO  = 4'h0;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;

   typedef enum logic {TX_IDLE, TX_SHIFT} slt_tx_state_e;

endpackage

// *** slt_tc_sva.sv ***
// Port checks for the transmit control block, bound to every instance.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/10ps
module slt_tc_sva (
   // Clock, reset and register strobes
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic        bus_init_i,
   input wire logic        csr_select_i,
   input wire logic        csr_read_i,
   input wire logic        csr_write_i,
   input wire logic [15:0] csr_wdata_i,
   // Outputs watched
   input wire logic [15:0] csr_rdata_o,
   input wire logic        bus_slave_sync_o,
   input wire logic        tx_line_o,
   input wire logic        rx_serial_o,
   input wire logic        rx_enable_o,
   input wire logic [1:0]  test_mode_select_o,
   input wire logic        clear_pulse_o,
   input wire logic        tx_irq_request_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // ------------------------------------------------------------
   // Write kinds
   // ------------------------------------------------------------
   wire logic wr_ok = csr_select_i && csr_write_i && !csr_wdata_i[8] && !bus_init_i;
   wire logic mrst  = csr_select_i && csr_write_i && csr_wdata_i[8];
   sequence quiet;
      !(csr_select_i && csr_write_i) && !bus_init_i;
   endsequence
   sequence loop_wr;
      wr_ok && csr_wdata_i[14] && csr_wdata_i[12:11] == 2'h1;
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   slave_sync_a: assert property (
      bus_slave_sync_o == (csr_select_i && (csr_read_i || csr_write_i)
                           && !(csr_write_i && csr_wdata_i[8])))
      else $error("slave sync wrong");
   clear_pulse_a: assert property (mrst |=> clear_pulse_o)
      else $error("no clear pulse");
   unit_reset_a: assert property (mrst ##1 quiet |=>
      test_mode_select_o == 2'h0 && tx_line_o && !tx_irq_request_o && !clear_pulse_o)
      else $error("master reset left state");
   init_idle_a: assert property (bus_init_i ##1 quiet |=>
      test_mode_select_o == 2'h0 && tx_line_o && rx_enable_o)
      else $error("init left state");
   mode_write_a: assert property (
      wr_ok |=> test_mode_select_o == $past(csr_wdata_i[12:11]))
      else $error("mode not stored");
   irq_enable_a: assert property (
      (wr_ok && !csr_wdata_i[6] && !csr_wdata_i[5]) |=> !tx_irq_request_o)
      else $error("irq while disabled");
   half_duplex_a: assert property (
      wr_ok |=> rx_enable_o == !($past(csr_wdata_i[3]) && $past(csr_wdata_i[4])))
      else $error("receiver enable wrong");
   break_line_a: assert property ((wr_ok && csr_wdata_i[0]) ##1 quiet |=> !tx_line_o)
      else $error("break not applied");
   loop_data_a: assert property (loop_wr ##1 quiet |=> rx_serial_o)
      else $error("loop data not steered");
   unused_bits_a: assert property ((csr_select_i && csr_read_i) |=>
      csr_rdata_o[9:8] == 2'h0 && csr_rdata_o[2:1] == 2'h0)
      else $error("unused bits not zero");
endmodule

bind slt_transmit_control slt_tc_sva chk_u (
   .ref_clk_i, .reset_n_i, .bus_init_i, .csr_select_i, .csr_read_i, .csr_write_i,
   .csr_wdata_i, .csr_rdata_o, .bus_slave_sync_o, .tx_line_o, .rx_serial_o, .rx_enable_o,
   .test_mode_select_o, .clear_pulse_o, .tx_irq_request_o
);

// *** slt_transmit_control.sv ***
// Transmit control register, transmit shifter with a character FIFO, and loop-test steering.
// Assumes bus strobes and init on ref_clk_i; link clocks and line come from the modem side.
`timescale 1ns/10ps

// ------------------------------------------------------------
// Character FIFO
// ------------------------------------------------------------
module slt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   import slt_pkg::*;

   // Pointers carry one extra wrap bit; DEPTH must be a power of two
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wptr;
      logic [AW:0]                 rptr;
   } slt_fifo_s;

   slt_fifo_s s_reg;
   slt_fifo_s s_next;
   logic      full;
   logic      empty;

   assign empty       = (s_reg.wptr == s_reg.rptr);
   assign full        = (s_reg.wptr[AW-1:0] == s_reg.rptr[AW-1:0]) &&
                        (s_reg.wptr[AW] != s_reg.rptr[AW]);
   assign in_ready_o  = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o  = s_reg.mem[s_reg.rptr[AW-1:0]];

   always_comb begin
      s_next = s_reg;
      if (in_valid_i && !full) begin
         s_next.mem[s_reg.wptr[AW-1:0]] = in_data_i;
         s_next.wptr = s_reg.wptr + 1'b1;
      end
      if (out_ready_i && !empty) begin
         s_next.rptr = s_reg.rptr + 1'b1;
      end
      if (flush_i) begin
         s_next.wptr = '0;
         s_next.rptr = '0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// ------------------------------------------------------------
// Top: transmit control and status
// ------------------------------------------------------------
module slt_transmit_control #(
   parameter int CHAR_BITS  = slt_pkg::CHAR_W,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic                       ref_clk_i,
   input  wire logic                       reset_n_i,
   input  wire logic                       bus_init_i,
   // Register strobes
   input  wire logic                       csr_select_i,
   input  wire logic                       csr_read_i,
   input  wire logic                       csr_write_i,
   input  wire logic [slt_pkg::CSR_W-1:0]  csr_wdata_i,
   output logic      [slt_pkg::CSR_W-1:0]  csr_rdata_o,
   output logic                            bus_slave_sync_o,
   // Transmit data buffer
   input  wire logic                       tx_buffer_load_strobe_i,
   input  wire logic [slt_pkg::CHAR_W-1:0] tx_data_i,
   output logic                            tx_buffer_ready_o,
   // Parameters held elsewhere in the unit
   input  wire logic                       sync_mode_i,
   input  wire logic [slt_pkg::CHAR_W-1:0] fill_char_i,
   // Modem link
   input  wire logic                       tx_bit_clk_i,
   input  wire logic                       rx_bit_clk_i,
   input  wire logic                       rx_line_i,
   output logic                            tx_line_o,
   // Towards receiver and rest of unit
   output logic                            rx_serial_o,
   output logic                            rx_bit_clk_o,
   output logic                            rx_enable_o,
   output logic      [1:0]                 test_mode_select_o,
   output logic                            clear_pulse_o,
   output logic                            tx_irq_request_o
);
   import slt_pkg::*;

   typedef struct packed {
      logic                  fill_sent_flag;
      logic                  loop_test_rx_input;
      logic                  ss_clk;
      logic [1:0]            test_mode_select;
      logic                  tx_done;
      logic                  tx_taken_irq_enable;
      logic                  fill_sent_irq_enable;
      logic                  send;
      logic                  half_duplex_select;
      logic                  brk;
      logic [2:0]            txc_sync;
      logic [1:0]            rxc_sync;
      logic [1:0]            rxd_sync;
      logic                  ss_prev;
      slt_tx_state_e         txs;
      logic [CHAR_W-1:0]     shifter;
      logic [CNT_W-1:0]      bits_left;
      logic                  in_msg;
      logic                  tx_bit;
      logic                  line;
      logic                  rx_in;
      logic                  rx_clk;
      logic [CSR_W-1:0]      rdata;
      logic                  clear;
   } slt_state_s;

   localparam logic [CNT_W-1:0] CHAR_CNT = CNT_W'(CHAR_BITS);

   slt_state_s        s_reg;
   slt_state_s        s_next;
   logic              fifo_valid;
   logic [CHAR_W-1:0] fifo_data;
   logic              fifo_pop;
   logic              clear_now;
   logic              rd_now;
   logic              wr_now;

   assign rd_now    = csr_select_i & csr_read_i;
   assign wr_now    = csr_select_i & csr_write_i;
   assign clear_now = wr_now & csr_wdata_i[BIT_UNIT_RESET];

   slt_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .flush_i     (clear_now | bus_init_i),
      .in_valid_i  (tx_buffer_load_strobe_i),
      .in_ready_o  (tx_buffer_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   always_comb begin
      logic loop;
      logic bit_evt;
      logic take_char;
      logic take_fill;
      s_next    = s_reg;
      fifo_pop  = 1'b0;
      take_char = 1'b0;
      take_fill = 1'b0;
      bit_evt   = 1'b0;
      loop      = (s_reg.test_mode_select == MODE_INT_LOOP) ||
                  (s_reg.test_mode_select == MODE_EXT_LOOP);

      // Two-stage synchronisers; edges seen between stage two and three
      s_next.txc_sync = {s_reg.txc_sync[1:0], tx_bit_clk_i};
      s_next.rxc_sync = {s_reg.rxc_sync[0], rx_bit_clk_i};
      s_next.rxd_sync = {s_reg.rxd_sync[0], rx_line_i};
      s_next.ss_prev  = s_reg.ss_clk;

      // Bits shift out on the falling bit-clock edge
      if (loop) begin
         bit_evt = s_reg.ss_prev & ~s_reg.ss_clk;
      end else begin
         bit_evt = s_reg.txc_sync[2] & ~s_reg.txc_sync[1];
      end

      // Register write; read-only, write-only and unused bits not stored
      if (wr_now) begin
         s_next.loop_test_rx_input   = csr_wdata_i[BIT_LOOP_DATA];
         s_next.ss_clk               = csr_wdata_i[BIT_SS_CLK];
         s_next.test_mode_select     = csr_wdata_i[BIT_MODE_HI:BIT_MODE_LO];
         s_next.tx_taken_irq_enable  = csr_wdata_i[BIT_TX_IE];
         s_next.fill_sent_irq_enable = csr_wdata_i[BIT_FILL_IE];
         s_next.send                 = csr_wdata_i[BIT_SEND];
         s_next.half_duplex_select   = csr_wdata_i[BIT_HALF_DUPLEX_SELECT];
         s_next.brk                  = csr_wdata_i[BIT_BREAK];
      end

      // Read captures the value before the read clear takes effect
      if (rd_now) begin
         s_next.rdata = CSR_ZERO;
         s_next.rdata[BIT_FILL_SENT]             = s_reg.fill_sent_flag;
         s_next.rdata[BIT_LOOP_DATA]             = s_reg.loop_test_rx_input;
         s_next.rdata[BIT_SS_CLK]                = s_reg.ss_clk;
         s_next.rdata[BIT_MODE_HI:BIT_MODE_LO]   = s_reg.test_mode_select;
         s_next.rdata[BIT_RX_MON]                = loop & s_reg.rx_in;
         s_next.rdata[BIT_DONE]                  = s_reg.tx_done;
         s_next.rdata[BIT_TX_IE]                 = s_reg.tx_taken_irq_enable;
         s_next.rdata[BIT_FILL_IE]               = s_reg.fill_sent_irq_enable;
         s_next.rdata[BIT_SEND]                  = s_reg.send;
         s_next.rdata[BIT_HALF_DUPLEX_SELECT]              = s_reg.half_duplex_select;
         s_next.rdata[BIT_BREAK]                 = s_reg.brk;
         s_next.fill_sent_flag                   = 1'b0;
      end

      if (tx_buffer_load_strobe_i) begin
         s_next.tx_done = 1'b0;
      end

      // Transmit shifter, LSB first
      if (bit_evt) begin
         if (s_reg.txs == TX_SHIFT && s_reg.bits_left > CNT_ONE) begin
            s_next.shifter   = {1'b1, s_reg.shifter[CHAR_W-1:1]};
            s_next.tx_bit    = s_reg.shifter[1];
            s_next.bits_left = s_reg.bits_left - CNT_ONE;
         end else if (s_reg.send && fifo_valid) begin
            take_char = 1'b1;
         end else if (s_reg.send && s_reg.in_msg && sync_mode_i) begin
            take_fill = 1'b1;
         end else begin
            // Character finished with send low or nothing to send
            s_next.txs       = TX_IDLE;
            s_next.in_msg    = 1'b0;
            s_next.bits_left = CNT_ZERO;
            s_next.tx_bit    = LINE_MARK;
         end
      end

      if (take_char || take_fill) begin
         s_next.txs       = TX_SHIFT;
         s_next.in_msg    = 1'b1;
         s_next.bits_left = CHAR_CNT;
         s_next.shifter   = take_char ? fifo_data : fill_char_i;
         s_next.tx_bit    = take_char ? fifo_data[0] : fill_char_i[0];
      end
      if (take_char) begin
         fifo_pop       = 1'b1;
         s_next.tx_done = 1'b1;
      end
      if (take_fill) begin
         s_next.fill_sent_flag = 1'b1;
      end

      // Receiver steering; loop modes feed the receiver from the register
      s_next.rx_in  = loop ? s_reg.loop_test_rx_input : s_reg.rxd_sync[1];
      s_next.rx_clk = loop ? s_reg.ss_clk : s_reg.rxc_sync[1];

      // Init or clear pulse returns control state and the shifter to idle
      if (bus_init_i || clear_now) begin
         s_next.fill_sent_flag       = 1'b0;
         s_next.loop_test_rx_input   = 1'b0;
         s_next.ss_clk               = 1'b0;
         s_next.test_mode_select     = MODE_NORMAL;
         s_next.tx_done              = 1'b1;
         s_next.tx_taken_irq_enable  = 1'b0;
         s_next.fill_sent_irq_enable = 1'b0;
         s_next.send                 = 1'b0;
         s_next.half_duplex_select   = 1'b0;
         s_next.brk                  = 1'b0;
         s_next.txs                  = TX_IDLE;
         s_next.shifter              = CHAR_ONES;
         s_next.bits_left            = CNT_ZERO;
         s_next.in_msg               = 1'b0;
         s_next.tx_bit               = LINE_MARK;
      end
      s_next.clear = clear_now;

      // Break overrides whatever the shifter presents
      s_next.line = s_next.brk ? LINE_SPACE : s_next.tx_bit;
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg          <= '0;
         s_reg.tx_done  <= 1'b1;
         s_reg.txs      <= TX_IDLE;
         s_reg.shifter  <= CHAR_ONES;
         s_reg.tx_bit   <= LINE_MARK;
         s_reg.line     <= LINE_MARK;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign csr_rdata_o        = s_reg.rdata;
   assign bus_slave_sync_o   = (rd_now | wr_now) & ~clear_now;
   assign tx_line_o          = s_reg.line;
   assign rx_serial_o        = s_reg.rx_in;
   assign rx_bit_clk_o       = s_reg.rx_clk;
   assign rx_enable_o        = ~(s_reg.half_duplex_select & s_reg.send);
   assign test_mode_select_o = s_reg.test_mode_select;
   assign clear_pulse_o      = s_reg.clear;
   assign tx_irq_request_o   = (s_reg.tx_taken_irq_enable & s_reg.tx_done) |
                               (s_reg.fill_sent_irq_enable & s_reg.fill_sent_flag);
endmodule

// *** tb_sync_line_transmit_control.sv ***
// Self-checking bench: registers, loop steering, resets, break and a full stream.
// Assumes the package, design, checker and modem model are compiled before it.
`timescale 1ns/10ps
module tb_sync_line_transmit_control;
   import slt_pkg::*;
   logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, bus_init_i = 1'b0, run = 1'b0;
   logic        csr_select_i = 1'b0, csr_read_i = 1'b0, csr_write_i = 1'b0;
   logic [15:0] csr_wdata_i = 16'h0000;
   logic        tx_buffer_load_strobe_i = 1'b0, sync_mode_i = 1'b0;
   logic [7:0]  tx_data_i = 8'h00, fill_char_i = 8'h00;
   logic [15:0] csr_rdata_o, count, d;
   logic [31:0] word;
   logic [1:0]  test_mode_select_o;
   logic        bus_slave_sync_o, tx_buffer_ready_o, tx_line_o, rx_serial_o, rx_bit_clk_o;
   logic        rx_enable_o, clear_pulse_o, tx_irq_request_o, tclk, rclk, rline, loop;
   int          failures = 0, comparisons = 0, cycles = 0;
   logic [7:0]  q[$];

   always #5 ref_clk_i = ~ref_clk_i;

   slt_transmit_control dut_u (
      .ref_clk_i, .reset_n_i, .bus_init_i, .csr_select_i, .csr_read_i, .csr_write_i,
      .csr_wdata_i, .csr_rdata_o, .bus_slave_sync_o, .tx_buffer_load_strobe_i, .tx_data_i,
      .tx_buffer_ready_o, .sync_mode_i, .fill_char_i, .tx_bit_clk_i(tclk),
      .rx_bit_clk_i(rclk), .rx_line_i(rline), .tx_line_o, .rx_serial_o, .rx_bit_clk_o,
      .rx_enable_o, .test_mode_select_o, .clear_pulse_o, .tx_irq_request_o);
   slt_modem_model modem_u (.run_i(run), .tx_line_i(tx_line_o), .tx_bit_clk_o(tclk),
      .rx_bit_clk_o(rclk), .rx_line_o(rline), .word_o(word), .count_o(count));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude;
      if (failures == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] v);
      @(posedge ref_clk_i);
      csr_select_i <= 1'b1;
      csr_write_i  <= 1'b1;
      csr_wdata_i  <= v;
      @(posedge ref_clk_i);
      csr_select_i <= 1'b0;
      csr_write_i  <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] e);
      @(posedge ref_clk_i);
      csr_select_i <= 1'b1;
      csr_read_i   <= 1'b1;
      @(posedge ref_clk_i);
      csr_select_i <= 1'b0;
      csr_read_i   <= 1'b0;
      #1;
      chk("rdata", 32'(csr_rdata_o), 32'(e));
   endtask
   task automatic upto(input int n);
      for (int k = 0; k < 4000 && int'(count) < n; k++) begin
         @(posedge ref_clk_i);
      end
      if (int'(count) < n) failures++;
   endtask

   // Hang guard, about three and a half times the expected run
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 7000) begin
         failures++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      void'($urandom(35430));
      rd(16'h0080);
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 16'h4809 : (i == 1) ? 16'h3010 : 16'($urandom) & 16'hfeff;
         loop = (d[12:11] == MODE_INT_LOOP) || (d[12:11] == MODE_EXT_LOOP);
         wr(d);
         rd((d & 16'h7879) | 16'h0080 | (loop ? {5'h00, d[14], 10'h000} : 16'h0000));
         chk("mode", 32'(test_mode_select_o), 32'(d[12:11]));
         chk("irq", 32'(tx_irq_request_o), 32'(d[6]));
         chk("rx_enable", 32'(rx_enable_o), 32'(!(d[3] && d[4])));
         if (loop) begin
            chk("rx_serial", 32'(rx_serial_o), 32'(d[14]));
            chk("rx_clock", 32'(rx_bit_clk_o), 32'(d[13]));
         end
      end
      @(posedge ref_clk_i);
      bus_init_i <= 1'b1;
      @(posedge ref_clk_i);
      bus_init_i <= 1'b0;
      rd(16'h0080);
      wr(16'h7879);
      wr(16'h0100);
      #1;
      chk("clear_pulse", 32'(clear_pulse_o), 32'h1);
      rd(16'h0080);
      wr(16'h0001);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("break", 32'(tx_line_o), 32'h0);
      wr(16'h0000);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("mark", 32'(tx_line_o), 32'h1);
      // Fill the buffer past full while the modem clock stands still
      @(posedge ref_clk_i);
      sync_mode_i <= 1'b1;
      fill_char_i <= 8'($urandom);
      wr(16'h0030);
      for (int i = 0; i < 17; i++) begin
         @(posedge ref_clk_i);
         d = 16'($urandom);
         tx_buffer_load_strobe_i <= 1'b1;
         tx_data_i <= d[7:0];
         if (q.size() < 16) q.push_back(d[7:0]);
      end
      @(posedge ref_clk_i);
      tx_buffer_load_strobe_i <= 1'b0;
      #1;
      chk("ready_full", 32'(tx_buffer_ready_o), 32'h0);
      rd(16'h0030);
      run <= 1'b1;
      upto(40);
      run <= 1'b0;
      repeat (50) @(posedge ref_clk_i);
      run <= 1'b1;
      upto(130);
      wr(16'h0020);
      upto(144);
      run <= 1'b0;
      chk("line_bits", word, {8'hff, fill_char_i, q[15], q[14]});
      chk("irq_fill", 32'(tx_irq_request_o), 32'h1);
      rd(16'h80a0);
      rd(16'h00a0);
      chk("ready_empty", 32'(tx_buffer_ready_o), 32'h1);
      conclude();
   end
endmodule
